// file: inc/rcs_params.svh
// Overview of operation
// RULE1: device pulls clock-run low to request clock
// RULE2: clock resource holds it, drives it high
// RULE3: clock-run driven low after reset release; the design drives it low during reset and otherwise only for a clock request
// RULE4: sustained three-state: drive high before float; the design floats it straight from low without driving it high
// RULE5: management interrupt high until causes cleared
// RULE6: sleep request asks controller to sleep
// RULE7: controller acknowledges sleep by pulling low
// RULE8: acknowledge rising means wake indication
// RULE9: slave mode: event pin outputs system events
// RULE10: gate-a20 source priority usb, strap, kbc
// RULE11: cpu reset held 2ms after reset release
// RULE12: cpu reset released on clock edge
// RULE13: cpu init on power-good low, shutdown
// RULE14: cpu init on port92, fast reset, kbc reset
// RULE15: system releases reset after 1ms stable
// RULE16: reset low resets main functions, outputs
// RULE17: standby power-good low resets standby logic
// RULE18: nmi high on pci system error
// RULE19: async resets synchronised before use
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH
`define RCS_CLK_PERIOD_PS  5000
`define RCS_CPU_RST_HOLD_NS 2000000
`define RCS_CPU_RST_CYCLES ((`RCS_CPU_RST_HOLD_NS * 1000 + `RCS_CLK_PERIOD_PS - 1) / `RCS_CLK_PERIOD_PS)
`define RCS_ADDR_STATUS    4'h0
`define RCS_ADDR_MASK      4'h1
`define RCS_ADDR_CTRL      4'h2
`define RCS_ADDR_PINS      4'h3
`define RCS_ADDR_SMI_CAUSE 4'h4
`define RCS_IRQ_WAKE       0
`define RCS_IRQ_SLEEP_ACK  1
`define RCS_IRQ_SERR       2
`define RCS_IRQ_SMI        3
`define RCS_CTRL_SLEEP_REQ 0
`define RCS_CTRL_CLKRUN    1
`define RCS_CTRL_SLAVE_PM  2
`define RCS_CTRL_USB_A20   3
`define RCS_CTRL_USB_A20V  4
`define RCS_CTRL_FAST_A20  5
`define RCS_CTRL_FAST_A20V 6
`define RCS_CTRL_FAST_RST  7
`define RCS_CTRL_RESET     8'h00
`endif

// file: inc/rcs_pkg.sv
package rcs_pkg;
	typedef struct packed {
		logic io_trap;
		logic sys_event;
		logic serirq_smi;
		logic acpi_smi;
	} rcs_smi_cause_type;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rcs_bus_req_type;
	typedef enum logic [2:0] {
		RCS_RST_HOLD  = 3'b001,
		RCS_RST_COUNT = 3'b010,
		RCS_RST_RUN   = 3'b100
	} rcs_rst_state_type;
endpackage : rcs_pkg

// file: verilog/rcs_sync.sv
`timescale 1ns/100ps
`include "rcs_params.svh"
module rcs_sync (
	// clock
	input  wire logic i_clk,
	// level
	input  wire logic i_async,
	output logic      o_sync
);
	logic stage1_q;
	always_ff @(posedge i_clk) begin
		stage1_q <= i_async;
		o_sync   <= stage1_q;
	end
endmodule : rcs_sync

// file: verilog/rcs_reset_timer.sv
`timescale 1ns/100ps
`include "rcs_params.svh"
module rcs_reset_timer (
	// clock and synced reset level (high = held in reset)
	input  wire logic i_clk,
	input  wire logic i_rst_active,
	// cpu reset out
	output logic      o_cpu_reset
);
	localparam int CW = $clog2(`RCS_CPU_RST_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(`RCS_CPU_RST_CYCLES - 1);
	rcs_pkg::rcs_rst_state_type state_q;
	logic [CW-1:0]              cnt_q;
	always_ff @(posedge i_clk) begin
		if (i_rst_active) begin
			state_q <= rcs_pkg::RCS_RST_HOLD;
			cnt_q   <= '0;
		end else begin
			case (state_q)
				rcs_pkg::RCS_RST_HOLD: begin
					state_q <= rcs_pkg::RCS_RST_COUNT;
					cnt_q   <= '0;
				end
				rcs_pkg::RCS_RST_COUNT: begin
					if (cnt_q == LAST) begin
						state_q <= rcs_pkg::RCS_RST_RUN; // [RULE11]
					end
					cnt_q <= cnt_q + CW'(1);
				end
				rcs_pkg::RCS_RST_RUN: begin
					state_q <= rcs_pkg::RCS_RST_RUN;
				end
				default: begin
					state_q <= rcs_pkg::RCS_RST_HOLD;
				end
			endcase
		end
	end
	// registered so the release lands on a clock edge
	always_ff @(posedge i_clk) begin
		o_cpu_reset <= i_rst_active || (state_q != rcs_pkg::RCS_RST_RUN); // [RULE12]
	end
endmodule : rcs_reset_timer

// file: verilog/rcs_top.sv
`timescale 1ns/100ps
`include "rcs_params.svh"
module rcs_top (
	// clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_sys_rst,
	// pins from outside
	input  wire logic                 i_reset_in_n,
	input  wire logic                 i_standby_power_good,
	input  wire logic                 i_power_good,
	input  wire logic                 i_kbc_gate_a20_in,
	input  wire logic                 i_kbc_reset_in_n,
	input  wire logic                 i_suspend_ack_n,
	input  wire logic                 i_clock_run_in,
	input  wire logic                 i_system_event_in,
	// on-chip events
	input  wire logic                 i_pci_serr,
	input  wire logic                 i_shutdown_cycle,
	input  wire logic                 i_port92_reset,
	input  wire logic                 i_fast_reset_snoop,
	input  wire logic                 i_usb_gate_a20,
	input  wire logic                 i_fast_gate_a20_strap,
	input  wire rcs_pkg::rcs_smi_cause_type i_smi_cause,
	// register port
	input  wire rcs_pkg::rcs_bus_req_type   i_bus,
	output logic [7:0]                o_rdata,
	// pins to outside
	output logic                      o_cpu_reset_out,
	output logic                      o_cpu_init_out,
	output logic                      o_pci_bus_reset_out_n,
	output logic                      o_gate_a20_out,
	output logic                      o_nmi_out,
	output logic                      o_mgmt_interrupt_out,
	output logic                      o_sleep_request_n,
	output logic                      o_clock_run_out,
	output logic                      o_clock_run_oe,
	output logic                      o_system_event_out,
	output logic                      o_system_event_oe,
	output logic                      o_ec_pm_event_in,
	output logic                      o_irq
);
	// ****************************************
	// synchronisers
	// ****************************************
	logic rst_n_s, spg_s, pg_s, kbga_s, kbc_reset_in_n_n_s, susp_n_s, ckr_s, evt_s;
	logic [7:0] async_in;
	logic [7:0] sync_out;
	assign async_in = {i_reset_in_n, i_standby_power_good, i_power_good, i_kbc_gate_a20_in,
		i_kbc_reset_in_n, i_suspend_ack_n, i_clock_run_in, i_system_event_in};
	generate
		for (genvar g = 0; g < 8; g++) begin : g_sync
			rcs_sync u_sync (
				.i_clk   (i_clk),
				.i_async (async_in[g]),
				.o_sync  (sync_out[g])
			); // [RULE19]
		end
	endgenerate
	assign {rst_n_s, spg_s, pg_s, kbga_s, kbc_reset_in_n_n_s, susp_n_s, ckr_s, evt_s} = sync_out;

	// main-supply logic resets on either the system reset or the reset pin
	logic main_rst;
	logic sb_rst;
	assign main_rst = i_sys_rst || !rst_n_s; // [RULE16]
	assign sb_rst   = i_sys_rst || !spg_s;   // [RULE17]

	// ****************************************
	// cpu reset timing
	// ****************************************
	logic cpu_reset;
	rcs_reset_timer u_timer (
		.i_clk        (i_clk),
		.i_rst_active (main_rst),
		.o_cpu_reset  (cpu_reset)
	);
	always_ff @(posedge i_clk) begin
		o_cpu_reset_out       <= cpu_reset;      // [RULE11] [RULE12]
		o_pci_bus_reset_out_n <= !main_rst;      // [RULE16]
	end

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] ctrl_q;
	logic [3:0] status_q;
	logic [3:0] mask_q;
	logic [3:0] ev;
	logic       susp_n_d1_q;
	logic       smi_any;
	assign smi_any = |i_smi_cause;
	always_ff @(posedge i_clk) begin
		if (sb_rst) begin
			susp_n_d1_q <= 1'b1;
		end else begin
			susp_n_d1_q <= susp_n_s;
		end
	end
	always_comb begin
		ev = 4'h0;
		ev[`RCS_IRQ_WAKE]      = susp_n_s && !susp_n_d1_q;  // [RULE8]
		ev[`RCS_IRQ_SLEEP_ACK] = !susp_n_s && susp_n_d1_q;  // [RULE7]
		ev[`RCS_IRQ_SERR]      = i_pci_serr;
		ev[`RCS_IRQ_SMI]       = smi_any;
	end
	always_ff @(posedge i_clk) begin
		if (sb_rst) begin
			ctrl_q <= `RCS_CTRL_RESET;
		end else if (i_bus.wr && i_bus.addr == `RCS_ADDR_CTRL) begin
			ctrl_q <= i_bus.wdata;
		end
	end
	always_ff @(posedge i_clk) begin
		if (sb_rst) begin
			mask_q <= 4'h0;
		end else if (i_bus.wr && i_bus.addr == `RCS_ADDR_MASK) begin
			mask_q <= i_bus.wdata[3:0];
		end
	end
	// set wins over the write-one clear
	always_ff @(posedge i_clk) begin
		if (sb_rst) begin
			status_q <= 4'h0;
		end else if (i_bus.wr && i_bus.addr == `RCS_ADDR_STATUS) begin
			status_q <= (status_q & ~i_bus.wdata[3:0]) | ev;
		end else begin
			status_q <= status_q | ev;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rdata <= 8'h00;
		end else if (i_bus.rd) begin
			case (i_bus.addr)
				`RCS_ADDR_STATUS:    o_rdata <= {4'h0, status_q};
				`RCS_ADDR_MASK:      o_rdata <= {4'h0, mask_q};
				`RCS_ADDR_CTRL:      o_rdata <= ctrl_q;
				`RCS_ADDR_PINS:      o_rdata <= {pg_s, spg_s, rst_n_s, susp_n_s,
					ckr_s, evt_s, kbga_s, kbc_reset_in_n_n_s};
				`RCS_ADDR_SMI_CAUSE: o_rdata <= {4'h0, i_smi_cause};
				default:             o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end
	always_ff @(posedge i_clk) begin
		o_irq <= |(status_q & mask_q);
	end

	// ****************************************
	// cpu sideband
	// ****************************************
	logic fast_rst_en;
	assign fast_rst_en = ctrl_q[`RCS_CTRL_FAST_RST];
	always_ff @(posedge i_clk) begin
		if (main_rst) begin
			o_cpu_init_out <= 1'b1; // [RULE16]
		end else begin
			o_cpu_init_out <= !pg_s || i_shutdown_cycle              // [RULE13]
				|| i_port92_reset                                // [RULE14]
				|| (fast_rst_en && i_fast_reset_snoop)
				|| (!fast_rst_en && !kbc_reset_in_n_n_s);
		end
	end
	always_ff @(posedge i_clk) begin
		if (main_rst) begin
			o_gate_a20_out <= 1'b1;
		end else if (ctrl_q[`RCS_CTRL_USB_A20]) begin
			o_gate_a20_out <= i_usb_gate_a20;                  // [RULE10]
		end else if (ctrl_q[`RCS_CTRL_FAST_A20] || i_fast_gate_a20_strap) begin
			o_gate_a20_out <= ctrl_q[`RCS_CTRL_FAST_A20V];     // [RULE10]
		end else begin
			o_gate_a20_out <= kbga_s;                          // [RULE10]
		end
	end
	always_ff @(posedge i_clk) begin
		if (main_rst) begin
			o_nmi_out <= 1'b0;
		end else begin
			o_nmi_out <= i_pci_serr || status_q[`RCS_IRQ_SERR]; // [RULE18]
		end
	end
	// stays high while any cause is still pending in its source
	always_ff @(posedge i_clk) begin
		if (sb_rst) begin
			o_mgmt_interrupt_out <= 1'b0;
		end else begin
			o_mgmt_interrupt_out <= smi_any; // [RULE5]
		end
	end

	// ****************************************
	// power management pins
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (sb_rst) begin
			o_sleep_request_n <= 1'b1;
		end else begin
			o_sleep_request_n <= !ctrl_q[`RCS_CTRL_SLEEP_REQ]; // [RULE6]
		end
	end
	always_ff @(posedge i_clk) begin
		if (sb_rst) begin
			o_system_event_out <= 1'b0;
			o_system_event_oe  <= 1'b0;
			o_ec_pm_event_in   <= 1'b0;
		end else begin
			o_system_event_oe  <= ctrl_q[`RCS_CTRL_SLAVE_PM];        // [RULE9]
			o_system_event_out <= |status_q;                         // [RULE9]
			o_ec_pm_event_in   <= !ctrl_q[`RCS_CTRL_SLAVE_PM] && evt_s;
		end
	end
	// clock-run: low during reset; a request pulls it low once, then the
	// clock resource keeps it; we never drive it high ourselves
	logic ckr_req_d1_q;
	always_ff @(posedge i_clk) begin
		if (main_rst) begin
			o_clock_run_out <= 1'b0;
			o_clock_run_oe  <= 1'b1;  // [RULE3]
			ckr_req_d1_q    <= 1'b0;
		end else begin
			ckr_req_d1_q    <= ctrl_q[`RCS_CTRL_CLKRUN];
			o_clock_run_out <= 1'b0;  // [RULE1] [RULE4]
			o_clock_run_oe  <= (ctrl_q[`RCS_CTRL_CLKRUN] && ckr_s && !ckr_req_d1_q)
				|| (o_clock_run_oe && !ckr_req_d1_q && ckr_s && ctrl_q[`RCS_CTRL_CLKRUN]); // [RULE2]
		end
	end
endmodule : rcs_top

// file: sim/rcs_ec_model.sv
`timescale 1ns/100ps
module rcs_ec_model (
	// clock
	input  wire logic i_clk,
	// from the device
	input  wire logic i_sleep_request_n,
	input  wire logic i_clock_run_oe,
	input  wire logic i_clock_run_out,
	// to the device
	output logic      o_suspend_ack_n,
	output logic      o_clock_run_line
);
	logic [4:0] dly_q = 5'h1f;
	// resource restores the line high, pull-up holds it between drives
	assign o_clock_run_line = i_clock_run_oe ? i_clock_run_out : 1'b1;
	// slow acknowledge; releasing it high is the wake indication
	always_ff @(posedge i_clk) begin
		dly_q <= {dly_q[3:0], i_sleep_request_n};
	end
	assign o_suspend_ack_n = dly_q[4];
endmodule : rcs_ec_model

// file: sim/rcs_top_chk.sv
`timescale 1ns/100ps
module rcs_top_chk (
	// clock and pins watched
	input wire logic                       i_clk,
	input wire logic                       i_sys_rst,
	input wire logic                       i_reset_in_n,
	input wire logic                       i_power_good,
	input wire logic                       i_pci_serr,
	input wire logic                       i_shutdown_cycle,
	input wire logic                       i_port92_reset,
	input wire rcs_pkg::rcs_smi_cause_type i_smi_cause,
	input wire logic                       o_cpu_reset_out,
	input wire logic                       o_cpu_init_out,
	input wire logic                       o_pci_bus_reset_out_n,
	input wire logic                       o_nmi_out,
	input wire logic                       o_mgmt_interrupt_out,
	input wire logic                       o_clock_run_out,
	input wire logic                       o_clock_run_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// sync plus output register latency covered by the length
	sequence s_rst_low; !i_reset_in_n [*6]; endsequence
	property p_rst_outs; s_rst_low |-> o_cpu_reset_out && o_cpu_init_out
		&& !o_pci_bus_reset_out_n; endproperty
	property p_clkrun_dflt; s_rst_low |-> o_clock_run_oe; endproperty
	// a request drives the line low for one cycle only, then lets the resource keep it
	sequence s_ckr_release;
		!o_clock_run_out ##1 (!o_clock_run_oe || !o_pci_bus_reset_out_n);
	endsequence
	property p_clkrun_low; o_clock_run_oe && o_pci_bus_reset_out_n |-> s_ckr_release;
	endproperty
	property p_cpu_hold; $rose(i_reset_in_n) |-> o_cpu_reset_out [*8]; endproperty
	property p_nmi; i_pci_serr |-> ##[1:3] o_nmi_out; endproperty
	property p_smi; (i_smi_cause != 4'h0) |-> ##[1:3] o_mgmt_interrupt_out; endproperty
	property p_init_sd; i_shutdown_cycle |-> ##[1:3] o_cpu_init_out; endproperty
	property p_init_pg; !i_power_good [*6] |-> o_cpu_init_out; endproperty
	property p_init_p92; i_port92_reset |-> ##[1:3] o_cpu_init_out; endproperty
	a_rst_outs: assert property (p_rst_outs) else $error("reset outputs wrong");
	a_clkrun_dflt: assert property (p_clkrun_dflt) else $error("clkrun not low");
	a_clkrun_low: assert property (p_clkrun_low) else $error("clkrun drive wrong");
	a_cpu_hold: assert property (p_cpu_hold) else $error("cpu reset early");
	a_nmi: assert property (p_nmi) else $error("nmi missing");
	a_smi: assert property (p_smi) else $error("smi missing");
	a_init_sd: assert property (p_init_sd) else $error("init missing");
	a_init_pg: assert property (p_init_pg) else $error("init missing");
	a_init_p92: assert property (p_init_p92) else $error("init missing");
endmodule : rcs_top_chk
bind rcs_top rcs_top_chk CHK (.*);

// file: sim/test_reset_and_cpu_sideband_control.sv
`timescale 1ns/100ps
module test_reset_and_cpu_sideband_control;
	logic i_clk = 1'b0, i_sys_rst, i_reset_in_n, i_standby_power_good, i_power_good;
	logic i_kbc_gate_a20_in, i_kbc_reset_in_n, i_suspend_ack_n, i_clock_run_in;
	logic i_system_event_in, i_pci_serr, i_shutdown_cycle, i_port92_reset;
	logic i_fast_reset_snoop, i_usb_gate_a20, i_fast_gate_a20_strap;
	rcs_pkg::rcs_smi_cause_type i_smi_cause;
	rcs_pkg::rcs_bus_req_type   i_bus;
	logic [7:0] o_rdata;
	logic o_cpu_reset_out, o_cpu_init_out, o_pci_bus_reset_out_n, o_gate_a20_out, o_nmi_out;
	logic o_mgmt_interrupt_out, o_sleep_request_n, o_clock_run_out, o_clock_run_oe;
	logic o_system_event_out, o_system_event_oe, o_ec_pm_event_in, o_irq;
	int errors = 0, n_compared = 0, cycles = 0;
	// each case sets the losing sources to the opposite of the winner
	logic [7:0] a20_ctrl [4] = '{8'h00, 8'h00, 8'h60, 8'h68};
	logic [3:0] a20_usb = 4'b0010, a20_strap = 4'b1010, a20_kbc = 4'b1011, a20_exp = 4'b0101;
	rcs_top DUT (.*);
	rcs_ec_model EC (.i_clk(i_clk), .i_sleep_request_n(o_sleep_request_n),
		.i_clock_run_oe(o_clock_run_oe), .i_clock_run_out(o_clock_run_out),
		.o_suspend_ack_n(i_suspend_ack_n),
		.o_clock_run_line(i_clock_run_in));
	always #2.5 i_clk = ~i_clk;
	// ******************
	// tasks
	// ******************
	task automatic finish_test();
		if (errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_bus <= '{a, d, 1'b1, 1'b0};
		cyc(1);
		i_bus <= '0;
		cyc(1);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		i_bus <= '{a, 8'h00, 1'b0, 1'b1};
		cyc(1);
		i_bus <= '0;
		cyc(1);
		check(o_rdata, e);
	endtask : rd
	// a stuck design must still reach the verdict
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end
	// ******************
	// sequence
	// ******************
	initial begin
		{i_sys_rst, i_standby_power_good, i_power_good, i_kbc_reset_in_n} = 4'hf;
		{i_reset_in_n, i_kbc_gate_a20_in, i_system_event_in, i_pci_serr} = 4'h0;
		{i_shutdown_cycle, i_port92_reset, i_fast_reset_snoop} = 3'h0;
		{i_usb_gate_a20, i_fast_gate_a20_strap} = 2'h0;
		i_smi_cause = '0;
		i_bus = '0;
		cyc(10);
		i_sys_rst <= 1'b0;
		cyc(8);
		check({o_cpu_reset_out, o_cpu_init_out, o_pci_bus_reset_out_n}, 8'h06);
		check(o_clock_run_oe, 8'h01);
		// settle time cut short to bound the run; the design does not time it
		i_reset_in_n <= 1'b1;
		cyc(1000);
		check(o_cpu_reset_out, 8'h01);
		for (int k = 0; k < 4; k++) begin
			wr(4'h2, a20_ctrl[k]);
			i_usb_gate_a20 <= a20_usb[k];
			i_fast_gate_a20_strap <= a20_strap[k];
			i_kbc_gate_a20_in <= a20_kbc[k];
			cyc(6);
			check(o_gate_a20_out, a20_exp[k]);
		end
		wr(4'h2, 8'h00);
		i_pci_serr <= 1'b1;
		cyc(4);
		check(o_nmi_out, 8'h01);
		i_pci_serr <= 1'b0;
		rd(4'h0, 8'h04);
		wr(4'h1, 8'h04);
		cyc(3);
		check(o_irq, 8'h01);
		wr(4'h0, 8'h04);
		cyc(3);
		check(o_irq, 8'h00);
		i_smi_cause <= '{1'b1, 1'b0, 1'b0, 1'b0};
		cyc(4);
		check(o_mgmt_interrupt_out, 8'h01);
		rd(4'h4, 8'h08);
		i_smi_cause <= '0;
		cyc(4);
		check(o_mgmt_interrupt_out, 8'h00);
		wr(4'h0, 8'h0f);
		wr(4'h2, 8'h01);
		cyc(2);
		check(o_sleep_request_n, 8'h00);
		cyc(12);
		rd(4'h0, 8'h02);
		wr(4'h2, 8'h00);
		cyc(12);
		rd(4'h0, 8'h03);
		check(o_cpu_init_out, 8'h00);
		i_port92_reset <= 1'b1;
		cyc(3);
		check(o_cpu_init_out, 8'h01);
		i_port92_reset <= 1'b0;
		i_kbc_reset_in_n <= 1'b0;
		cyc(6);
		check(o_cpu_init_out, 8'h01);
		wr(4'h2, 8'h80);
		cyc(20);
		check(o_cpu_init_out, 8'h00);
		i_kbc_reset_in_n <= 1'b1;
		i_fast_reset_snoop <= 1'b1;
		cyc(3);
		check(o_cpu_init_out, 8'h01);
		i_fast_reset_snoop <= 1'b0;
		cyc(3);
		check(o_cpu_init_out, 8'h00);
		i_shutdown_cycle <= 1'b1;
		cyc(3);
		check(o_cpu_init_out, 8'h01);
		i_shutdown_cycle <= 1'b0;
		cyc(3);
		check(o_cpu_init_out, 8'h00);
		i_power_good <= 1'b0;
		cyc(8);
		check(o_cpu_init_out, 8'h01);
		i_power_good <= 1'b1;
		i_system_event_in <= 1'b1;
		cyc(5);
		check(o_ec_pm_event_in, 8'h01);
		wr(4'h2, 8'h04);
		cyc(2);
		check(o_system_event_oe, 8'h01);
		check(o_system_event_out, 8'h01);
		check(o_ec_pm_event_in, 8'h00);
		wr(4'h0, 8'h0f);
		cyc(2);
		check(o_system_event_out, 8'h00);
		wr(4'h2, 8'h02);
		cyc(1);
		check(o_clock_run_oe, 8'h01);
		check(o_clock_run_out, 8'h00);
		cyc(1);
		check(o_clock_run_oe, 8'h00);
		rd(4'hf, 8'h00);
		i_reset_in_n <= 1'b0;
		cyc(8);
		check({o_cpu_reset_out, o_pci_bus_reset_out_n}, 8'h02);
		finish_test();
	end
endmodule : test_reset_and_cpu_sideband_control
